/* File: mmuat_top.sv */
// address translation and protection unit with avalon register slave
`timescale 1ns/1ps
`default_nettype none
module mmuat_top import mmuat_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic instr_xlate_enable_in,
  input wire logic data_xlate_enable_in,
  input wire logic user_privilege_flag_in,
  input wire logic xl_req_in,
  input wire logic xl_instr_in,
  input wire logic xl_store_in,
  input wire logic xl_spec_in,
  input wire logic [31:0] xl_ea_in,
  output logic xl_done_out,
  output logic [31:0] xl_pa_out,
  output logic xl_defer_out,
  output logic instr_storage_exception_out,
  output logic data_storage_exception_out,
  output logic walk_req_out,
  output logic [39:0] walk_vpn_out,
  output logic [18:0] walk_hash_out,
  input wire logic walk_ack_in,
  input wire logic walk_found_in,
  input wire logic [31:0] walk_pte_in,
  output logic upd_req_out,
  output logic [1:0] upd_rc_out,
  input wire logic upd_ack_in
);
  logic rst_meta_q, rst_b;
  logic [31:0] seg_q [SEG_COUNT];
  logic [31:0] ibat_q [2*BAT_COUNT];
  logic [31:0] dbat_q [2*BAT_COUNT];
  logic [4:0] status_q;
  mmuat_state_e st_q;
  logic [31:0] ea_q;
  logic instr_q, store_q, spec_q, user_q, xlen_q;
  logic [31:0] sr;
  logic [VSID_BITS-1:0] vsid;
  logic key, bat_any, bg, bviol, pviol, thit, ihit, dhit;
  logic [14:0] bat_pa;
  logic [1:0] bat_pp;
  logic [TD_BITS-1:0] tdat, idat, ddat, fill_data;
  logic [TAG_BITS-1:0] tag;
  logic [4:0] cause_d;
  logic walk_d, setc_d, defer_d, look, r_clr, c_clr;
  logic [31:0] pa_d;
  logic [BAT_COUNT-1:0] bhit;
  logic [14:0] bmask [BAT_COUNT];

  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      if (be[b]) o[8*b +: 8] = n[8*b +: 8];
    end
    return o;
  endfunction

  // reset released through two flops
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_q <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_b <= rst_meta_q;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b);

  // avalon slave: one wait cycle, then answer
  logic acc, wr_ok;
  assign acc = avs_read_in || avs_write_in;
  assign wr_ok = avs_write_in && !avs_waitrequest_out;
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= REG_RESET;
    end else begin
      avs_waitrequest_out <= !(acc && avs_waitrequest_out);
      if (avs_read_in && avs_waitrequest_out) begin
        if (avs_address_in[7:6] == REG_SEG_PAGE) begin
          avs_readdata_out <= seg_q[avs_address_in[5:2]];
        end else if (avs_address_in[7:5] == REG_IBAT_PAGE) begin
          avs_readdata_out <= ibat_q[avs_address_in[4:2]];
        end else if (avs_address_in[7:5] == REG_DBAT_PAGE) begin
          avs_readdata_out <= dbat_q[avs_address_in[4:2]];
        end else if (avs_address_in == REG_STATUS) begin
          avs_readdata_out <= {27'h0, status_q};
        end else begin
          avs_readdata_out <= REG_RESET;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < SEG_COUNT; i++) seg_q[i] <= REG_RESET;
      for (int i = 0; i < 2*BAT_COUNT; i++) begin
        ibat_q[i] <= REG_RESET;
        dbat_q[i] <= REG_RESET;
      end
    end else if (wr_ok) begin
      if (avs_address_in[7:6] == REG_SEG_PAGE) begin
        seg_q[avs_address_in[5:2]] <= be_merge(seg_q[avs_address_in[5:2]],
                                                avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in[7:5] == REG_IBAT_PAGE) begin
        ibat_q[avs_address_in[4:2]] <= be_merge(ibat_q[avs_address_in[4:2]],
                                                 avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in[7:5] == REG_DBAT_PAGE) begin
        dbat_q[avs_address_in[4:2]] <= be_merge(dbat_q[avs_address_in[4:2]],
                                                 avs_writedata_in, avs_byteenable_in);
      end
    end
  end

  // segment select and virtual page
  assign sr = seg_q[ea_q[31:28]];
  assign vsid = sr[VSID_BITS-1:0];
  assign key = user_q ? sr[SR_KP_POS] : sr[SR_KS_POS];
  assign tag = {vsid, ea_q[27:18]};
  assign look = (st_q == S_LOOK);

  // block array, lowest matching entry wins
  for (genvar i = 0; i < BAT_COUNT; i++) begin : g_bat
    logic [31:0] up;
    assign up = instr_q ? ibat_q[2*i] : dbat_q[2*i];
    assign bmask[i] = {4'hf, ~up[BATU_BL_LSB +: BL_BITS]};
    assign bhit[i] = ((ea_q[31:17] ^ up[31:17]) & bmask[i]) == 15'h0
                     && (user_q ? up[BATU_VP_POS] : up[BATU_VS_POS]);
  end
  always_comb begin
    logic [31:0] lo;
    lo = REG_RESET;
    bat_pa = ea_q[31:17];
    for (int i = BAT_COUNT-1; i >= 0; i--) begin
      if (bhit[i]) begin
        lo = instr_q ? ibat_q[2*i+1] : dbat_q[2*i+1];
        bat_pa = (lo[31:17] & bmask[i]) | (ea_q[31:17] & ~bmask[i]);
      end
    end
    bat_pp = lo[1:0];
    bg = lo[BATL_G_POS];
  end
  assign bat_any = |bhit;

  mmuat_prot u_bprot (.key_in(1'b1), .pp_in(bat_pp), .store_in(store_q), .viol_out(bviol));
  mmuat_prot u_pprot (.key_in(key), .pp_in(tdat[TD_PP_LSB +: 2]), .store_in(store_q),
                      .viol_out(pviol));

  mmuat_tlb u_instr_xlate_buffer (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b), .set_in(ea_q[17:12]),
                    .tag_in(tag), .touch_in(look && instr_q), .fill_in(walk_ack_in &&
                    walk_found_in && st_q == S_WALK && instr_q), .fill_data_in(fill_data),
                    .setc_in(1'b0), .hit_out(ihit), .data_out(idat));
  mmuat_tlb u_data_xlate_buffer (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b), .set_in(ea_q[17:12]),
                    .tag_in(tag), .touch_in(look && !instr_q), .fill_in(walk_ack_in &&
                    walk_found_in && st_q == S_WALK && !instr_q), .fill_data_in(fill_data),
                    .setc_in(look && setc_d), .hit_out(dhit), .data_out(ddat));
  assign thit = instr_q ? ihit : dhit;
  assign tdat = instr_q ? idat : ddat;

  // history bits the table search has to set
  assign r_clr = !walk_pte_in[PTE_R_POS];
  assign c_clr = store_q && !walk_pte_in[PTE_C_POS];
  assign fill_data = {walk_pte_in[31:12], walk_pte_in[1:0], walk_pte_in[PTE_G_POS],
                      walk_pte_in[PTE_C_POS] | store_q};

  // translation decision for the held access
  always_comb begin
    cause_d = 5'h0;
    walk_d = 1'b0;
    setc_d = 1'b0;
    defer_d = 1'b0;
    pa_d = ea_q;
    if (xlen_q) begin
      if (bat_any) begin
        pa_d = {bat_pa, ea_q[BLK_OFF_BITS-1:0]};
        if (instr_q && bg) cause_d[CS_NOEX] = 1'b1;
        else if (bviol) cause_d[CS_PROT] = 1'b1;
        else if (spec_q && bg) defer_d = 1'b1;
      end else if (sr[SR_T_POS]) begin
        cause_d[CS_DSEG] = 1'b1;
      end else if (!thit) begin
        walk_d = 1'b1;
      end else begin
        pa_d = {tdat[TD_PPN_LSB +: 20], ea_q[PAGE_BITS-1:0]};
        if (instr_q && (sr[SR_N_POS] || tdat[TD_G])) cause_d[CS_NOEX] = 1'b1;
        else if (pviol) cause_d[CS_PROT] = 1'b1;
        else if (spec_q && tdat[TD_G]) defer_d = 1'b1;
        else if (store_q && !tdat[TD_C]) setc_d = 1'b1;
      end
      if (cause_d != 5'h0) cause_d[CS_INSTR] = instr_q;
    end
  end

  // translation sequence
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= S_IDLE;
      ea_q <= REG_RESET;
      {instr_q, store_q, spec_q, user_q, xlen_q} <= 5'h0;
      status_q <= 5'h0;
      xl_done_out <= 1'b0;
      xl_pa_out <= REG_RESET;
      xl_defer_out <= 1'b0;
      instr_storage_exception_out <= 1'b0;
      data_storage_exception_out <= 1'b0;
      walk_req_out <= 1'b0;
      walk_vpn_out <= 40'h0;
      walk_hash_out <= 19'h0;
      upd_req_out <= 1'b0;
      upd_rc_out <= 2'h0;
    end else begin
      xl_done_out <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (xl_req_in) begin
            ea_q <= xl_ea_in;
            instr_q <= xl_instr_in;
            store_q <= xl_store_in && !xl_instr_in;
            spec_q <= xl_spec_in;
            user_q <= user_privilege_flag_in;
            xlen_q <= xl_instr_in ? instr_xlate_enable_in : data_xlate_enable_in;
            st_q <= S_LOOK;
          end
        end
        S_LOOK: begin
          walk_vpn_out <= {vsid, ea_q[27:12]};
          walk_hash_out <= vsid[18:0] ^ {3'h0, ea_q[27:12]};
          if (walk_d) begin
            walk_req_out <= 1'b1;
            st_q <= S_WALK;
          end else if (setc_d) begin
            upd_req_out <= 1'b1;
            upd_rc_out <= 2'h1;
            st_q <= S_UPD;
          end else begin
            xl_done_out <= 1'b1;
            xl_pa_out <= pa_d;
            xl_defer_out <= defer_d;
            instr_storage_exception_out <= (cause_d != 5'h0) && instr_q;
            data_storage_exception_out <= (cause_d != 5'h0) && !instr_q;
            if (cause_d != 5'h0) status_q <= cause_d;
            st_q <= S_IDLE;
          end
        end
        S_WALK: begin
          if (walk_ack_in) begin
            walk_req_out <= 1'b0;
            if (!walk_found_in) begin
              xl_done_out <= 1'b1;
              xl_pa_out <= ea_q;
              xl_defer_out <= 1'b0;
              instr_storage_exception_out <= instr_q;
              data_storage_exception_out <= !instr_q;
              status_q <= {instr_q, 3'h0, 1'b1};
              st_q <= S_IDLE;
            end else if (r_clr || c_clr) begin
              upd_req_out <= 1'b1;
              upd_rc_out <= {r_clr || store_q, store_q};
              st_q <= S_UPD;
            end else begin
              st_q <= S_LOOK;
            end
          end
        end
        S_UPD: begin
          if (upd_ack_in) begin
            upd_req_out <= 1'b0;
            st_q <= S_LOOK;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  logic dec_page;
  assign dec_page = look && xlen_q && !bat_any && !sr[SR_T_POS];

  property p_offset;
    xl_done_out |-> xl_pa_out[PAGE_BITS-1:0] == ea_q[PAGE_BITS-1:0];
  endproperty
  a_offset: assert property (p_offset) else $error("page offset altered");

  property p_real;
    look && !xlen_q |=> xl_done_out && xl_pa_out == $past(ea_q)
      && !instr_storage_exception_out && !data_storage_exception_out;
  endproperty
  a_real: assert property (p_real) else $error("real mode address wrong");

  property p_block;
    look && xlen_q && bat_any && !bviol && !bg |=> xl_done_out
      && xl_pa_out[31:17] == $past(bat_pa) && xl_pa_out[16:0] == $past(ea_q[16:0]);
  endproperty
  a_block: assert property (p_block) else $error("block result wrong");

  property p_dseg;
    look && xlen_q && !bat_any && sr[SR_T_POS] |=> xl_done_out
      && instr_storage_exception_out == $past(instr_q)
      && data_storage_exception_out == !$past(instr_q);
  endproperty
  a_dseg: assert property (p_dseg) else $error("direct-store not faulted");

  property p_miss;
    dec_page && !thit |=> walk_req_out && st_q == S_WALK;
  endproperty
  a_miss: assert property (p_miss) else $error("miss without search");

  property p_nofind;
    st_q == S_WALK && walk_ack_in && !walk_found_in |=> xl_done_out
      && (instr_storage_exception_out || data_storage_exception_out);
  endproperty
  a_nofind: assert property (p_nofind) else $error("page fault missing");

  property p_noexec;
    dec_page && thit && instr_q && sr[SR_N_POS] |=> xl_done_out && instr_storage_exception_out;
  endproperty
  a_noexec: assert property (p_noexec) else $error("no-execute fetch allowed");

  property p_setc;
    dec_page && thit && store_q && !tdat[TD_C] && !pviol && !spec_q
      |=> upd_req_out && upd_rc_out[0] ##1 !look;
  endproperty
  a_setc: assert property (p_setc) else $error("changed bit not set");

  property p_guard;
    look && xlen_q && spec_q && !instr_q && bat_any && bg && !bviol |=> xl_done_out
      && xl_defer_out;
  endproperty
  a_guard: assert property (p_guard) else $error("guarded speculative access");

  property p_walkrc;
    st_q == S_WALK && walk_ack_in && walk_found_in && store_q
      && !walk_pte_in[PTE_C_POS] |=> upd_req_out && upd_rc_out == 2'h3;
  endproperty
  a_walkrc: assert property (p_walkrc) else $error("store search rc wrong");
endmodule
`default_nettype wire

/* File: mmuat_pkg.sv */
// shared constants and types for the address translation unit
package mmuat_pkg;
  localparam int PAGE_BITS = 12;
  localparam int BLK_OFF_BITS = 17;
  localparam int SEG_COUNT = 16;
  localparam int BAT_COUNT = 4;
  localparam int TLB_SETS = 64;
  localparam int TLB_WAYS = 2;
  localparam int SET_BITS = 6;
  localparam int VSID_BITS = 24;
  localparam int TAG_BITS = 34;
  localparam int BL_BITS = 11;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [1:0] REG_SEG_PAGE = 2'h1;
  localparam logic [2:0] REG_IBAT_PAGE = 3'h4;
  localparam logic [2:0] REG_DBAT_PAGE = 3'h5;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam int SR_T_POS = 31;
  localparam int SR_KS_POS = 30;
  localparam int SR_KP_POS = 29;
  localparam int SR_N_POS = 28;
  localparam int BATU_VS_POS = 1;
  localparam int BATU_VP_POS = 0;
  localparam int BATU_BL_LSB = 2;
  localparam int BATL_G_POS = 3;
  localparam int PTE_R_POS = 8;
  localparam int PTE_C_POS = 7;
  localparam int PTE_G_POS = 3;
  localparam int TD_C = 0;
  localparam int TD_G = 1;
  localparam int TD_PP_LSB = 2;
  localparam int TD_PPN_LSB = 4;
  localparam int TD_BITS = 24;
  localparam int CS_FAULT = 0;
  localparam int CS_PROT = 1;
  localparam int CS_DSEG = 2;
  localparam int CS_NOEX = 3;
  localparam int CS_INSTR = 4;
  localparam logic [1:0] PP_RW = 2'h2;
  localparam logic [1:0] PP_RO = 2'h3;
  localparam logic [1:0] PP_NONE = 2'h0;
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_LOOK = 4'h2,
    S_WALK = 4'h4,
    S_UPD = 4'h8
  } mmuat_state_e;
endpackage

/* File: mmuat_prot.sv */
// page and block permission check
`timescale 1ns/1ps
`default_nettype none
module mmuat_prot import mmuat_pkg::*; (
  input wire logic key_in,
  input wire logic [1:0] pp_in,
  input wire logic store_in,
  output logic viol_out
);
  // key set: no access, read-only, or read/write; key clear: only read-only denies writes
  always_comb begin
    if (key_in) begin
      viol_out = (pp_in == PP_NONE) || (store_in && pp_in != PP_RW);
    end else begin
      viol_out = store_in && (pp_in == PP_RO);
    end
  end
endmodule
`default_nettype wire

/* File: mmuat_tlb.sv */
// two-way set associative translation buffer with lru replacement
`timescale 1ns/1ps
`default_nettype none
module mmuat_tlb import mmuat_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [SET_BITS-1:0] set_in,
  input wire logic [TAG_BITS-1:0] tag_in,
  input wire logic touch_in,
  input wire logic fill_in,
  input wire logic [TD_BITS-1:0] fill_data_in,
  input wire logic setc_in,
  output logic hit_out,
  output logic [TD_BITS-1:0] data_out
);
  logic [TLB_WAYS-1:0] vld_q [TLB_SETS];
  logic [TAG_BITS-1:0] tag_q [TLB_SETS][TLB_WAYS];
  logic [TD_BITS-1:0] dat_q [TLB_SETS][TLB_WAYS];
  logic lru_q [TLB_SETS];
  logic [TLB_WAYS-1:0] hitv;
  logic hway;

  for (genvar w = 0; w < TLB_WAYS; w++) begin : g_way
    assign hitv[w] = vld_q[set_in][w] && (tag_q[set_in][w] == tag_in);
  end
  assign hway = hitv[1];
  assign hit_out = |hitv;
  assign data_out = dat_q[set_in][hway];

  // 64 sets of two ways, victim is the least recently used way
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int s = 0; s < TLB_SETS; s++) begin
        vld_q[s] <= '0;
        lru_q[s] <= 1'b0;
      end
    end else if (fill_in) begin
      vld_q[set_in][lru_q[set_in]] <= 1'b1;
      lru_q[set_in] <= ~lru_q[set_in];
    end else if (touch_in && hit_out) begin
      lru_q[set_in] <= ~hway;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (fill_in) begin
      tag_q[set_in][lru_q[set_in]] <= tag_in;
      dat_q[set_in][lru_q[set_in]] <= fill_data_in;
    end else if (setc_in && hit_out) begin
      dat_q[set_in][hway][TD_C] <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: mmuat_walk_model.sv */
// memory-side table search and history update model for the translation unit
`timescale 1ns/1ps
`default_nettype none
module mmuat_walk_model (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic walk_req_in,
  input wire logic upd_req_in,
  input wire logic [1:0] upd_rc_in,
  input wire logic cfg_found_in,
  input wire logic [31:0] cfg_pte_in,
  input wire logic [3:0] cfg_delay_in,
  output logic walk_ack_out,
  output logic walk_found_out,
  output logic [31:0] walk_pte_out,
  output logic upd_ack_out,
  output logic [1:0] upd_rc_seen_out,
  output logic [7:0] upd_count_out
);
  logic [3:0] w_cnt_q;
  logic [3:0] u_cnt_q;
  logic w_done_q;
  logic u_done_q;
  // answers a search after the set delay; result lines toggle outside the answer cycle
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      walk_ack_out <= 1'b0;
      walk_found_out <= 1'b0;
      walk_pte_out <= 32'h0;
      w_cnt_q <= 4'h0;
      w_done_q <= 1'b0;
    end else begin
      walk_ack_out <= 1'b0;
      if (walk_req_in && !w_done_q && w_cnt_q == cfg_delay_in) begin
        walk_ack_out <= 1'b1;
        walk_found_out <= cfg_found_in;
        walk_pte_out <= cfg_pte_in;
        w_done_q <= 1'b1;
        w_cnt_q <= 4'h0;
      end else begin
        if (walk_req_in && !w_done_q) begin
          w_cnt_q <= w_cnt_q + 4'h1;
        end
        if (!walk_req_in) begin
          w_done_q <= 1'b0;
        end
        walk_found_out <= ~walk_found_out;
        walk_pte_out <= ~walk_pte_out;
      end
    end
  end
  // takes referenced/changed updates and records what was asked
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      upd_ack_out <= 1'b0;
      upd_rc_seen_out <= 2'h0;
      upd_count_out <= 8'h0;
      u_cnt_q <= 4'h0;
      u_done_q <= 1'b0;
    end else begin
      upd_ack_out <= 1'b0;
      if (upd_req_in && !u_done_q && u_cnt_q == cfg_delay_in) begin
        upd_ack_out <= 1'b1;
        upd_rc_seen_out <= upd_rc_in;
        upd_count_out <= upd_count_out + 8'h1;
        u_done_q <= 1'b1;
        u_cnt_q <= 4'h0;
      end else if (upd_req_in && !u_done_q) begin
        u_cnt_q <= u_cnt_q + 4'h1;
      end else if (!upd_req_in) begin
        u_done_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: mmuat_top_tb_top.sv */
// self-checking bench for the address translation unit
`timescale 1ns/1ps
`default_nettype none
module mmuat_top_tb_top import mmuat_pkg::*; ;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] a_adr = 8'h0;
  logic a_rd = 1'b0;
  logic a_wr = 1'b0;
  logic [31:0] a_wd = 32'h0;
  logic [31:0] a_rdd;
  logic a_wt;
  logic ien = 1'b0;
  logic den = 1'b0;
  logic usr = 1'b0;
  logic req = 1'b0;
  logic ins = 1'b0;
  logic sto = 1'b0;
  logic spc = 1'b0;
  logic [31:0] ea = 32'h0;
  logic done, dfr, iex, dex, wreq, ureq, wack, wfnd, uack;
  logic [31:0] pa, wpte, rd, r_pa;
  logic [39:0] wvpn, vpn_seen;
  logic [18:0] whash, hash_seen;
  logic [1:0] urc, rc_seen;
  logic [7:0] ucnt;
  logic m_found = 1'b1;
  logic [31:0] m_pte = 32'h0;
  logic [3:0] m_dly = 4'h0;
  logic r_ie, r_de, r_df;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  int walks = 0;
  always #5 clk = ~clk;
  mmuat_top DUT (.clk_sys_in(clk), .rst_b_in(rst_b), .avs_address_in(a_adr),
    .avs_read_in(a_rd), .avs_write_in(a_wr), .avs_writedata_in(a_wd),
    .avs_byteenable_in(4'hf), .avs_readdata_out(a_rdd), .avs_waitrequest_out(a_wt),
    .instr_xlate_enable_in(ien), .data_xlate_enable_in(den), .user_privilege_flag_in(usr),
    .xl_req_in(req), .xl_instr_in(ins), .xl_store_in(sto), .xl_spec_in(spc), .xl_ea_in(ea),
    .xl_done_out(done), .xl_pa_out(pa), .xl_defer_out(dfr),
    .instr_storage_exception_out(iex), .data_storage_exception_out(dex),
    .walk_req_out(wreq), .walk_vpn_out(wvpn), .walk_hash_out(whash), .walk_ack_in(wack),
    .walk_found_in(wfnd), .walk_pte_in(wpte), .upd_req_out(ureq), .upd_rc_out(urc),
    .upd_ack_in(uack));
  mmuat_walk_model PEER (.clk_sys_in(clk), .rst_b_in(rst_b), .walk_req_in(wreq),
    .upd_req_in(ureq), .upd_rc_in(urc), .cfg_found_in(m_found), .cfg_pte_in(m_pte),
    .cfg_delay_in(m_dly), .walk_ack_out(wack), .walk_found_out(wfnd), .walk_pte_out(wpte),
    .upd_ack_out(uack), .upd_rc_seen_out(rc_seen), .upd_count_out(ucnt));
  always @(posedge clk) begin
    cyc++;
    if (wack === 1'b1) begin
      walks++;
      vpn_seen = wvpn;
      hash_seen = whash;
    end
    if (cyc == 20000) begin
      failures++;
      $display("MISMATCH run_length expected below 20000 seen 20000");
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    a_adr <= ad;
    a_wd <= wd;
    a_wr <= w;
    a_rd <= !w;
    do begin
      @(posedge clk);
    end while (a_wt !== 1'b0);
    rd = a_rdd;
    a_rd <= 1'b0;
    a_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic xl(input logic i, input logic s, input logic sp, input logic u,
                    input logic [31:0] e);
    int n;
    req <= 1'b1;
    ins <= i;
    sto <= s;
    spc <= sp;
    usr <= u;
    ea <= e;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 100);
    chk("xl_done", 1'b1, done);
    r_pa = pa;
    r_ie = iex;
    r_de = dex;
    r_df = dfr;
  endtask
  task automatic t_regs();
    bus(1'b0, REG_STATUS, 32'h0);
    chk("status_reset", REG_RESET, rd);
    bus(1'b1, REG_STATUS, 32'h0000_001f);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("status_ro", REG_RESET, rd);
    bus(1'b1, 8'hf0, 32'hffff_ffff);
    bus(1'b0, 8'hf0, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, 8'h64, 32'h2000_0111);
    bus(1'b0, 8'h64, 32'h0);
    chk("seg9", 32'h2000_0111, rd);
    bus(1'b1, 8'h4c, 32'h005a_5a5a);
    bus(1'b1, 8'h54, 32'h8000_0000);
    bus(1'b1, 8'h68, 32'h1000_0222);
  endtask
  task automatic t_real();
    den <= 1'b1;
    xl(1'b1, 1'b0, 1'b0, 1'b1, 32'h5000_0010);
    chk("real_fetch_pa", 32'h5000_0010, r_pa);
    chk("real_fetch_ie", 1'b0, r_ie);
    den <= 1'b0;
    ien <= 1'b1;
    xl(1'b0, 1'b0, 1'b0, 1'b1, 32'h5000_0014);
    chk("real_data_pa", 32'h5000_0014, r_pa);
    chk("real_data_de", 1'b0, r_de);
    xl(1'b1, 1'b0, 1'b0, 1'b0, 32'h5000_0020);
    chk("dstore_ie", 1'b1, r_ie);
    den <= 1'b1;
    xl(1'b0, 1'b1, 1'b0, 1'b0, 32'h5000_0020);
    chk("dstore_de", 1'b1, r_de);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("status_dseg", 32'h1 << CS_DSEG, rd);
  endtask
  task automatic t_page();
    int w0;
    m_pte <= {20'h12345, 12'h002};
    m_dly <= 4'h3;
    xl(1'b0, 1'b0, 1'b0, 1'b0, 32'h3abc_d123);
    chk("page_pa", 32'h1234_5123, r_pa);
    chk("vpn", {24'h5a5a5a, 16'habcd}, vpn_seen);
    chk("hash", 19'h25a5a ^ 19'h0abcd, hash_seen);
    chk("load_rc", 2'b10, rc_seen);
    w0 = walks;
    xl(1'b0, 1'b1, 1'b0, 1'b0, 32'h3abc_d456);
    chk("hit_pa", 32'h1234_5456, r_pa);
    chk("store_hit_rc", 2'b01, rc_seen);
    chk("store_hit_upd", 8'h2, ucnt);
    xl(1'b0, 1'b1, 1'b0, 1'b1, 32'h3abc_d789);
    chk("c_set_upd", 8'h2, ucnt);
    chk("hit_walks", w0, walks);
    m_pte <= {20'h00777, 12'h102};
    m_dly <= 4'h0;
    xl(1'b0, 1'b1, 1'b0, 1'b0, 32'h3abc_e010);
    chk("store_miss_pa", 32'h0077_7010, r_pa);
    chk("store_miss_rc", 2'b11, rc_seen);
    m_found <= 1'b0;
    xl(1'b0, 1'b0, 1'b0, 1'b0, 32'h3abc_f000);
    chk("fault_de", 1'b1, r_de);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("status_fault", 32'h1 << CS_FAULT, rd);
    m_found <= 1'b1;
  endtask
  task automatic t_block();
    int w0;
    bus(1'b1, 8'ha0, 32'h7000_0007);
    bus(1'b1, 8'ha4, 32'h0840_0002);
    bus(1'b1, 8'ha8, 32'h6000_0003);
    bus(1'b1, 8'hac, 32'h0900_000a);
    w0 = walks;
    xl(1'b0, 1'b1, 1'b0, 1'b1, 32'h7003_1234);
    chk("block_pa", 32'h0843_1234, r_pa);
    chk("block_walks", w0, walks);
    xl(1'b0, 1'b0, 1'b1, 1'b0, 32'h6000_0100);
    chk("guard_defer", 1'b1, r_df);
    xl(1'b0, 1'b0, 1'b0, 1'b0, 32'h6000_0100);
    chk("guard_defer_off", 1'b0, r_df);
    chk("guard_pa", 32'h0900_0100, r_pa);
    bus(1'b1, 8'h80, 32'h7000_0007);
    bus(1'b1, 8'h84, 32'h0840_0002);
    bus(1'b1, 8'h88, 32'h6000_0003);
    bus(1'b1, 8'h8c, 32'h0900_000a);
    xl(1'b1, 1'b0, 1'b0, 1'b0, 32'h7003_1234);
    chk("iblock_pa", 32'h0843_1234, r_pa);
    chk("iblock_ie", 1'b0, r_ie);
    xl(1'b1, 1'b0, 1'b0, 1'b0, 32'h6000_0100);
    chk("iguard_ie", 1'b1, r_ie);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("status_iguard", (32'h1 << CS_NOEX) | (32'h1 << CS_INSTR), rd);
  endtask
  task automatic t_prot();
    logic [31:0] pte_q[4] = '{32'h00aa_a180, 32'h00bb_b181, 32'h00cc_c183, 32'h00dd_d182};
    m_pte <= pte_q[0];
    xl(1'b0, 1'b0, 1'b0, 1'b0, 32'h9000_1000);
    chk("sup_only_sup", 1'b0, r_de);
    xl(1'b0, 1'b0, 1'b0, 1'b1, 32'h9000_1004);
    chk("sup_only_user", 1'b1, r_de);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("status_prot", 32'h1 << CS_PROT, rd);
    m_pte <= pte_q[1];
    xl(1'b0, 1'b0, 1'b0, 1'b1, 32'h9000_2000);
    chk("swo_user_rd", 1'b0, r_de);
    xl(1'b0, 1'b1, 1'b0, 1'b1, 32'h9000_2004);
    chk("swo_user_wr", 1'b1, r_de);
    xl(1'b0, 1'b1, 1'b0, 1'b0, 32'h9000_2008);
    chk("swo_sup_wr", 1'b0, r_de);
    m_pte <= pte_q[2];
    xl(1'b0, 1'b1, 1'b0, 1'b0, 32'h9000_3000);
    chk("ro_sup_wr", 1'b1, r_de);
    xl(1'b0, 1'b1, 1'b0, 1'b1, 32'h3abc_d000);
    chk("both_user_wr", 1'b0, r_de);
    m_pte <= pte_q[3];
    xl(1'b1, 1'b0, 1'b0, 1'b0, 32'ha000_0040);
    chk("noexec_fetch", 1'b1, r_ie);
    xl(1'b0, 1'b0, 1'b0, 1'b1, 32'ha000_0040);
    chk("noexec_data", 1'b0, r_de);
    chk("noexec_pa", 32'h00dd_d040, r_pa);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_real();
    t_page();
    t_block();
    t_prot();
    complete_run();
  end
endmodule
`default_nettype wire
